// [inc/diag_adc_pkg.sv]
// Constants and types for the diagnostic converter control block.
// Assumes a single 20 MHz clock domain and an external SAR analog core.
package diag_adc_pkg;

    // ==================================================
    // Widths and channel codes
    localparam int CHAN_W = 5;
    localparam int CODE_W = 8;
    localparam int SAR_BITS = 8;
    // Extra cycles per bit: trial code register plus comparator synchroniser
    localparam logic [1:0] COMP_WAIT = 2'h3;
    localparam int GROUPS = 8;
    localparam int GROUP_W = 3;
    localparam int PER_GROUP = 3;
    localparam logic [4:0] CH_REF_PIN = 5'h00;
    localparam logic [4:0] CH_SUPPLY = 5'h01;
    localparam logic [4:0] CH_REGULATOR = 5'h02;
    localparam logic [4:0] CH_TEMP = 5'h03;
    localparam logic [4:0] CH_REF_CUR = 5'h04;
    localparam logic [4:0] CH_BATTERY = 5'h05;
    localparam logic [4:0] CH_HIGHEST = 5'h06;
    localparam logic [4:0] CH_RESERVED = 5'h07;
    localparam logic [4:0] CH_FIRST_OUT = 5'h08;

    // ==================================================
    // Reset values
    localparam logic [4:0] CHAN_RESET = 5'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;

    // ==================================================
    // Conversion sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETTLE = 3'b001,
        ST_CONVERT = 3'b010,
        ST_NEXT = 3'b011,
        ST_DONE = 3'b100
    } conv_state_t;

endpackage

// [core/sar_stepper.sv]
// Successive-approximation bit stepper for one 8-bit conversion.
// Assumes comp_high_in answers a trial code COMP_WAIT cycles after it changes.
`timescale 1ns/10ps

module sar_stepper #(
    parameter int BITS = 8
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic abort_in,
    input wire logic comp_high_in,
    output logic [BITS-1:0] trial_out,
    output logic busy_out,
    output logic done_out
);

    logic [BITS-1:0] trial_reg;
    logic [BITS-1:0] trial_next;
    logic [BITS-1:0] bit_reg;
    logic [BITS-1:0] bit_next;
    logic busy_reg;
    logic busy_next;
    logic [1:0] wait_reg;
    logic [1:0] wait_next;
    logic done_reg;
    logic done_next;

    // ==================================================
    // Next-state: test one bit every COMP_WAIT+1 cycles, MSB first
    always_comb begin
        trial_next = trial_reg;
        bit_next = bit_reg;
        busy_next = busy_reg;
        wait_next = wait_reg;
        done_next = 1'b0;
        if (abort_in) begin
            busy_next = 1'b0;
        end else if (start_in) begin
            bit_next = {1'b1, {(BITS-1){1'b0}}};
            trial_next = {1'b1, {(BITS-1){1'b0}}};
            busy_next = 1'b1;
            wait_next = diag_adc_pkg::COMP_WAIT;
        end else if (busy_reg && (wait_reg != 2'h0)) begin
            // Hold the trial until its comparator answer has crossed the synchroniser
            wait_next = wait_reg - 2'h1;
        end else if (busy_reg) begin
            // Comparator says input below trial: drop the bit
            if (comp_high_in) begin
                trial_next = trial_reg & ~bit_reg;
            end
            bit_next = bit_reg >> 1;
            trial_next = trial_next | (bit_reg >> 1);
            wait_next = diag_adc_pkg::COMP_WAIT;
            if (bit_reg[0]) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            trial_reg <= '0;
            bit_reg <= '0;
            busy_reg <= 1'b0;
            wait_reg <= 2'h0;
            done_reg <= 1'b0;
        end else begin
            trial_reg <= trial_next;
            bit_reg <= bit_next;
            busy_reg <= busy_next;
            wait_reg <= wait_next;
            done_reg <= done_next;
        end
    end

    assign trial_out = trial_reg;
    assign busy_out = busy_reg;
    assign done_out = done_reg;

endmodule

// [core/diag_adc_ctrl.sv]
// Conversion control for the 8-bit diagnostic converter.
// Assumes register strobes come from the device's serial register logic on
// sys_clk_in, and the comparator output from the analog core (asynchronous).
`timescale 1ns/10ps

module diag_adc_ctrl #(
    parameter int SETTLE_CYCLES = 4
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Register access from the serial interface logic
    input wire logic chan_wr_in,
    input wire logic [4:0] chan_wdata_in,
    input wire logic result_rd_done_in,
    // Group state from the dimming logic
    input wire logic [7:0] group_on_in,
    input wire logic [23:0] out_enable_in,
    // Analog core
    input wire logic comp_high_in,
    output logic [4:0] source_sel_out,
    output logic [7:0] dac_code_out,
    // Register read-back
    output logic [4:0] adc_channel_select_out,
    output logic [7:0] adc_result_out,
    output logic conversion_done_flag_out,
    output logic busy_out
);

    logic comp_meta_reg;
    logic comp_sync_reg;
    logic [7:0] group_meta_reg;
    logic [7:0] group_sync_reg;

    diag_adc_pkg::conv_state_t state_reg;
    diag_adc_pkg::conv_state_t state_next;
    logic [4:0] chan_reg;
    logic [4:0] chan_next;
    logic [7:0] result_reg;
    logic [7:0] result_next;
    logic done_flag_reg;
    logic done_flag_next;
    logic [4:0] src_reg;
    logic [4:0] src_next;
    logic [2:0] group_reg;
    logic [2:0] group_next;
    logic [1:0] member_reg;
    logic [1:0] member_next;
    logic [7:0] max_reg;
    logic [7:0] max_next;
    logic [7:0] settle_reg;
    logic [7:0] settle_next;
    logic sar_start;
    logic sar_abort;
    logic [7:0] sar_trial;
    logic sar_busy;
    logic sar_done;
    logic busy_reg;

    // ==================================================
    // Output channel code for a group and member
    function automatic logic [4:0] out_code(input logic [2:0] grp, input logic [1:0] mem);
        out_code = diag_adc_pkg::CH_FIRST_OUT + 5'(grp) * 5'(diag_adc_pkg::PER_GROUP)
            + 5'(mem);
    endfunction

    // ==================================================
    // Input synchronisers
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            comp_meta_reg <= 1'b0;
            comp_sync_reg <= 1'b0;
            group_meta_reg <= 8'h00;
            group_sync_reg <= 8'h00;
        end else begin
            comp_meta_reg <= comp_high_in;
            comp_sync_reg <= comp_meta_reg;
            group_meta_reg <= group_on_in;
            group_sync_reg <= group_meta_reg;
        end
    end

    sar_stepper #(
        .BITS(diag_adc_pkg::SAR_BITS)
    ) u_sar (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .start_in(sar_start),
        .abort_in(sar_abort),
        .comp_high_in(comp_sync_reg),
        .trial_out(sar_trial),
        .busy_out(sar_busy),
        .done_out(sar_done)
    );

    // ==================================================
    // Conversion sequencer
    always_comb begin
        state_next = state_reg;
        chan_next = chan_reg;
        result_next = result_reg;
        done_flag_next = done_flag_reg;
        src_next = src_reg;
        group_next = group_reg;
        member_next = member_reg;
        max_next = max_reg;
        settle_next = settle_reg;
        sar_start = 1'b0;
        sar_abort = 1'b0;
        unique case (state_reg)
            diag_adc_pkg::ST_IDLE: begin
            end
            diag_adc_pkg::ST_SETTLE: begin
                if (src_reg == diag_adc_pkg::CH_HIGHEST) begin
                    // Scan: skip disabled outputs, wait for the group's on time
                    if (!out_enable_in[5'(group_reg) * 5'd3 + 5'(member_reg)]) begin
                        state_next = diag_adc_pkg::ST_NEXT;
                    end else if (group_sync_reg[group_reg]) begin
                        sar_start = 1'b1;
                        state_next = diag_adc_pkg::ST_CONVERT;
                    end
                end else if (settle_reg == 8'h00) begin
                    sar_start = 1'b1;
                    state_next = diag_adc_pkg::ST_CONVERT;
                end else begin
                    settle_next = settle_reg - 8'h01;
                end
            end
            diag_adc_pkg::ST_CONVERT: begin
                if (sar_done) begin
                    if (src_reg == diag_adc_pkg::CH_HIGHEST) begin
                        if (sar_trial > max_reg) begin
                            max_next = sar_trial;
                        end
                        state_next = diag_adc_pkg::ST_NEXT;
                    end else begin
                        result_next = sar_trial;
                        done_flag_next = 1'b1;
                        state_next = diag_adc_pkg::ST_IDLE;
                    end
                end
            end
            diag_adc_pkg::ST_NEXT: begin
                state_next = diag_adc_pkg::ST_SETTLE;
                if (member_reg == 2'd2) begin
                    member_next = 2'd0;
                    if (group_reg == 3'(diag_adc_pkg::GROUPS - 1)) begin
                        result_next = max_reg;
                        done_flag_next = 1'b1;
                        state_next = diag_adc_pkg::ST_IDLE;
                    end else begin
                        group_next = group_reg + 3'd1;
                    end
                end else begin
                    member_next = member_reg + 2'd1;
                end
            end
            default: begin
                state_next = diag_adc_pkg::ST_IDLE;
            end
        endcase
        // A read or channel write starts over on the selected channel, or idles on CH_RESERVED
        if (chan_wr_in || result_rd_done_in) begin
            if (chan_wr_in) begin
                chan_next = chan_wdata_in;
            end
            sar_abort = 1'b1;
            done_flag_next = 1'b0;
            group_next = 3'd0;
            member_next = 2'd0;
            max_next = diag_adc_pkg::RESULT_RESET;
            settle_next = 8'(SETTLE_CYCLES);
            if (chan_next == diag_adc_pkg::CH_RESERVED) begin
                state_next = diag_adc_pkg::ST_IDLE;
            end else begin
                src_next = chan_next;
                state_next = diag_adc_pkg::ST_SETTLE;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= diag_adc_pkg::ST_IDLE;
            chan_reg <= diag_adc_pkg::CHAN_RESET;
            result_reg <= diag_adc_pkg::RESULT_RESET;
            done_flag_reg <= 1'b0;
            src_reg <= diag_adc_pkg::CHAN_RESET;
            group_reg <= 3'd0;
            member_reg <= 2'd0;
            max_reg <= diag_adc_pkg::RESULT_RESET;
            settle_reg <= 8'h00;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            chan_reg <= chan_next;
            result_reg <= result_next;
            done_flag_reg <= done_flag_next;
            src_reg <= src_next;
            group_reg <= group_next;
            member_reg <= member_next;
            max_reg <= max_next;
            settle_reg <= settle_next;
            busy_reg <= (state_next != diag_adc_pkg::ST_IDLE);
        end
    end

    // ==================================================
    // Outputs
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            source_sel_out <= diag_adc_pkg::CHAN_RESET;
            dac_code_out <= 8'h00;
        end else begin
            // Highest-output scan steers the mux to the output under test
            source_sel_out <= (src_next == diag_adc_pkg::CH_HIGHEST) ?
                out_code(group_next, member_next) : src_next;
            dac_code_out <= sar_trial;
        end
    end

    assign adc_channel_select_out = chan_reg;
    assign adc_result_out = result_reg;
    assign conversion_done_flag_out = done_flag_reg;
    assign busy_out = busy_reg;

endmodule

// [tb/analog_source_model.sv]
// Behavioural analog core: source level compared against the trial code.
// Assumes source code c carries the level c*8+3; no settling lag.
`timescale 1ns/10ps

module analog_source_model (
    input wire logic [4:0] source_sel_in,
    input wire logic [7:0] dac_code_in,
    output logic comp_high_out
);
    // ==================================================
    // Comparator: high while the source lies below the trial code
    assign comp_high_out = ({source_sel_in, 3'b011} < dac_code_in);
endmodule

// [tb/diag_adc_ctrl_chk.sv]
// Checker for the converter control ports.
// Assumes it is bound to diag_adc_ctrl; single clock, async active-low reset.
`timescale 1ns/10ps

module diag_adc_ctrl_chk (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic chan_wr_in,
    input wire logic [4:0] chan_wdata_in,
    input wire logic result_rd_done_in,
    input wire logic [4:0] source_sel_out,
    input wire logic [4:0] adc_channel_select_out,
    input wire logic [7:0] adc_result_out,
    input wire logic conversion_done_flag_out,
    input wire logic busy_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // ==================================================
    // Properties
    a_wr_clears_flag: assert property (chan_wr_in |=> !conversion_done_flag_out)
        else $error("flag not cleared by channel write");
    a_wr_starts_busy: assert property (chan_wr_in && chan_wdata_in != 5'h07 |=> busy_out)
        else $error("conversion not started by channel write");
    a_chan_loaded: assert property (chan_wr_in |=> adc_channel_select_out == $past(chan_wdata_in))
        else $error("channel register not loaded");
    a_reserved_idle: assert property (chan_wr_in && chan_wdata_in == 5'h07 |=> !busy_out[*3])
        else $error("reserved code started a conversion");
    a_rd_clears_flag: assert property (result_rd_done_in |=> !conversion_done_flag_out)
        else $error("flag not cleared by result read");
    a_done_ends_busy: assert property ($rose(conversion_done_flag_out) |-> $fell(busy_out))
        else $error("flag rose without conversion ending");
    a_result_stands: assert property (conversion_done_flag_out && !chan_wr_in
        && !result_rd_done_in |=> $stable(adc_result_out) && conversion_done_flag_out)
        else $error("result changed while flag set");
    a_done_bounded: assert property (chan_wr_in && chan_wdata_in != 5'h06
        && chan_wdata_in != 5'h07 |-> ##[1:50]
        (conversion_done_flag_out || chan_wr_in || result_rd_done_in))
        else $error("conversion did not finish in time");
    a_busy_no_flag: assert property (busy_out |-> !conversion_done_flag_out)
        else $error("flag high while converting");
    a_source_match: assert property (busy_out && adc_channel_select_out != 5'h06
        |-> source_sel_out == adc_channel_select_out)
        else $error("mux source differs from channel");
    c_done: cover property ($rose(conversion_done_flag_out));
    c_scan: cover property (busy_out && adc_channel_select_out == 5'h06);
    c_abort: cover property (busy_out && chan_wr_in);
endmodule

// [tb/diag_adc_conversion_control_tb.sv]
// Testbench for diag_adc_ctrl with the behavioural analog core.
// Assumes a 20 MHz clock and the one-cycle strobes of the register logic.
`timescale 1ns/10ps

module diag_adc_conversion_control_tb;
    logic sys_clk_in, rst_n_in, chan_wr_in, result_rd_done_in, comp_high_in;
    logic [4:0] chan_wdata_in, source_sel_out, adc_channel_select_out;
    logic [7:0] group_on_in, dac_code_out, adc_result_out;
    logic [23:0] out_enable_in;
    logic conversion_done_flag_out, busy_out;
    int fail_count, n_tests;

    diag_adc_ctrl #(.SETTLE_CYCLES(4)) diag_adc_ctrl_inst (.sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in), .chan_wr_in(chan_wr_in), .chan_wdata_in(chan_wdata_in),
        .result_rd_done_in(result_rd_done_in), .group_on_in(group_on_in),
        .out_enable_in(out_enable_in), .comp_high_in(comp_high_in),
        .source_sel_out(source_sel_out), .dac_code_out(dac_code_out),
        .adc_channel_select_out(adc_channel_select_out), .adc_result_out(adc_result_out),
        .conversion_done_flag_out(conversion_done_flag_out), .busy_out(busy_out));
    analog_source_model analog_source_model_inst (.source_sel_in(source_sel_out),
        .dac_code_in(dac_code_out), .comp_high_out(comp_high_in));

    always #25 sys_clk_in = ~sys_clk_in;

    // ==================================================
    // Tasks
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic strobe(input logic rd, input logic [4:0] code);
        @(posedge sys_clk_in);
        chan_wr_in <= !rd;
        result_rd_done_in <= rd;
        chan_wdata_in <= code;
        @(posedge sys_clk_in);
        chan_wr_in <= 1'b0;
        result_rd_done_in <= 1'b0;
        #1 check("flag after request", 8'h00, {7'h00, conversion_done_flag_out});
    endtask
    task automatic wait_done(input logic [7:0] exp);
        int i;
        for (i = 0; i < 3000 && conversion_done_flag_out !== 1'b1; i++) begin
            @(posedge sys_clk_in);
            #1;
        end
        check("result", exp, adc_result_out);
        check("trial code", exp, dac_code_out);
        check("flag", 8'h01, {7'h00, conversion_done_flag_out});
    endtask
    function automatic logic [7:0] scan_max(input logic [23:0] en);
        logic [7:0] m;
        m = 8'h00;
        for (int k = 0; k < 24; k++) begin
            if (en[k] && (k * 8 + 67) > m) m = 8'(k * 8 + 67);
        end
        return m;
    endfunction
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ==================================================
    // Sequence
    initial begin
        sys_clk_in = 1'b0;
        rst_n_in = 1'b0;
        chan_wr_in = 1'b0;
        result_rd_done_in = 1'b0;
        chan_wdata_in = 5'h00;
        group_on_in = 8'hff;
        out_enable_in = 24'hff_ffff;
        repeat (2) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        #1 check("reset result", 8'h00, adc_result_out);
        check("reset state", 8'h00,
            {1'b0, adc_channel_select_out, conversion_done_flag_out, busy_out});
        for (int c = 0; c < 32; c++) begin
            if (c == 7) continue;
            strobe(1'b0, 5'(c));
            check("channel", 8'(c), {3'h0, adc_channel_select_out});
            wait_done(c == 6 ? scan_max(out_enable_in) : 8'(c * 8 + 3));
        end
        strobe(1'b1, 5'h00);
        wait_done(8'hfb);
        strobe(1'b0, 5'h01);
        repeat (5) @(posedge sys_clk_in);
        strobe(1'b0, 5'h05);
        wait_done(8'h2b);
        out_enable_in <= 24'h7f_fffe;
        group_on_in <= 8'h00;
        repeat (20) @(posedge sys_clk_in);
        strobe(1'b0, 5'h06);
        repeat (200) @(posedge sys_clk_in);
        #1 check("flag while groups off", 8'h00, {7'h00, conversion_done_flag_out});
        group_on_in <= 8'hff;
        wait_done(scan_max(24'h7f_fffe));
        strobe(1'b0, 5'h07);
        repeat (3) @(posedge sys_clk_in);
        #1 check("busy on reserved", 8'h00, {7'h00, busy_out});
        close_out();
    end

    initial begin
        repeat (20000) @(posedge sys_clk_in);
        fail_count++;
        close_out();
    end
endmodule

bind diag_adc_ctrl diag_adc_ctrl_chk diag_adc_ctrl_chk_inst (.sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in), .chan_wr_in(chan_wr_in), .chan_wdata_in(chan_wdata_in),
    .result_rd_done_in(result_rd_done_in), .source_sel_out(source_sel_out),
    .adc_channel_select_out(adc_channel_select_out), .adc_result_out(adc_result_out),
    .conversion_done_flag_out(conversion_done_flag_out), .busy_out(busy_out));
